// *** verilog/mic_pkg.sv ***
// Package: register indices, bit layout, source numbering, vectors and edge codes of the interrupt controller
package mic_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] REG_IE_LINE0  = 6'h00;
    localparam logic [5:0] REG_LINE1_TA  = 6'h01;
    localparam logic [5:0] REG_TB_TC     = 6'h02;
    localparam logic [5:0] REG_TD_CONV   = 6'h03;
    localparam logic [5:0] REG_LINE2_3   = 6'h22;
    localparam logic [5:0] REG_LINE4_SER = 6'h23;
    localparam logic [5:0] REG_ESR_ONE   = 6'h26;
    localparam logic [5:0] REG_ESR_TWO   = 6'h27;
    localparam int         ADDR_LSB      = 2;
    localparam int         ADDR_W        = 8;
    localparam int         REG_W         = 4;

    // ------------------------------------------------------------
    // Bit positions inside a four-bit control register
    // ------------------------------------------------------------
    localparam int BIT_IE    = 0;
    localparam int BIT_FLAG0 = 0;
    localparam int BIT_MASK0 = 1;
    localparam int BIT_FLAG1 = 2;
    localparam int BIT_MASK1 = 3;

    // ------------------------------------------------------------
    // Source numbering, in priority order
    // ------------------------------------------------------------
    localparam int NUM_SRC    = 11;
    localparam int NUM_PIN    = 5;
    localparam int NUM_SYNC   = 6;
    localparam int SRC_LINE0  = 0;
    localparam int SRC_LINE1  = 1;
    localparam int SRC_TA     = 2;
    localparam int SRC_TB     = 3;
    localparam int SRC_LINE2  = 4;
    localparam int SRC_TC     = 5;
    localparam int SRC_LINE3  = 6;
    localparam int SRC_TD     = 7;
    localparam int SRC_LINE4  = 8;
    localparam int SRC_CONV   = 9;
    localparam int SRC_SER    = 10;
    localparam int SYNC_TIMER_D_EVENT_INPUT  = 5;
    localparam int NUM_GROUP  = 7;

    // Members of each vector group, lowest priority first
    localparam logic [NUM_GROUP-1:0][NUM_SRC-1:0] GROUP_MEMBERS = '{
        11'h600, 11'h180, 11'h060, 11'h018, 11'h004, 11'h002, 11'h001};

    // ------------------------------------------------------------
    // Vector addresses
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [NUM_GROUP-1:0][15:0] GROUP_VECTOR = '{
        16'h000E, 16'h000C, 16'h000A, 16'h0008, 16'h0006, 16'h0004, 16'h0002};

    // ------------------------------------------------------------
    // Reset values and edge-select codes
    // ------------------------------------------------------------
    localparam logic [NUM_SRC-1:0] FLAGS_RESET = 11'h000;
    localparam logic [NUM_SRC-1:0] MASKS_RESET = 11'h7FF;
    localparam logic [3:0]         ESR_RESET   = 4'h0;
    localparam logic [1:0]         EDGE_NONE   = 2'h0;
    localparam logic [1:0]         EDGE_FALL   = 2'h1;
    localparam logic [1:0]         EDGE_RISE   = 2'h2;
    localparam logic [1:0]         EDGE_BOTH   = 2'h3;

    typedef enum logic [1:0] {
        MIC_IDLE   = 2'b00,
        MIC_FINISH = 2'b01,
        MIC_PUSH_A = 2'b10,
        MIC_PUSH_B = 2'b11
    } mic_phase_e;

endpackage : mic_pkg

// *** verilog/mic_irq_ctrl.sv ***
// Module: eleven-source interrupt controller with fixed priority, vectors and Avalon-MM registers
module mic_irq_ctrl
    import mic_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // External pins, active low, and peripheral events
    input  wire logic [NUM_PIN-1:0]   ext_irq_line_n,
    input  wire logic                 timer_d_event_input,
    input  wire logic                 capture_mode,
    input  wire logic                 timer_a_overflow,
    input  wire logic                 timer_b_overflow,
    input  wire logic                 timer_c_overflow,
    input  wire logic                 timer_d_overflow,
    input  wire logic                 serial_done,
    input  wire logic                 converter_done,
    input  wire logic                 stop_mode,
    input  wire logic                 stop_cancel_input,
    // Instruction sequencer
    input  wire logic                 irq_accept,
    input  wire logic                 return_from_irq_instr,
    output logic                      irq_request,
    output logic                      stop_cancel_request,
    output logic      [15:0]          irq_vector,
    output logic                      finish_cycle,
    output logic                      stack_push,
    output logic                      vector_jump,
    output logic                      global_irq_enable
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 ie;
        logic [NUM_SRC-1:0]   flag;
        logic [NUM_SRC-1:0]   mask;
        logic [3:0]           esr_one;
        logic [3:0]           esr_two;
        logic [NUM_SYNC-1:0]  sync_a;
        logic [NUM_SYNC-1:0]  sync_b;
        logic [NUM_SYNC-1:0]  sync_c;
        logic [15:0]          vector;
        mic_phase_e           phase;
        logic                 ack;
        logic [REG_W-1:0]     rdata;
    } mic_state_s;

    mic_state_s st_reg;
    mic_state_s st_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Decodes one two-bit edge code against two successive pin samples
    function automatic logic edge_hit(input logic [1:0] code, input logic prev, input logic cur);
        logic fall;
        logic rise;
        fall = prev & ~cur;
        rise = ~prev & cur;
        unique case (code)
            EDGE_NONE: edge_hit = 1'b0;
            EDGE_FALL: edge_hit = fall;
            EDGE_RISE: edge_hit = rise;
            EDGE_BOTH: edge_hit = fall | rise;
        endcase
    endfunction : edge_hit

    // Register image: flag in the even bit, mask in the odd bit of each pair
    function automatic logic [REG_W-1:0] pair_bits(input mic_state_s s, input int lo, input int hi);
        pair_bits = {s.mask[hi], s.flag[hi], s.mask[lo], s.flag[lo]};
    endfunction : pair_bits

    // ------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0]   pending;
    logic [NUM_GROUP-1:0] group_hit;
    logic [15:0]          enc_vector;
    logic                 any_pending;

    assign pending = st_reg.flag & ~st_reg.mask;

    genvar g;
    generate
        for (g = 0; g < NUM_GROUP; g++) begin : g_group
            assign group_hit[g] = |(pending & GROUP_MEMBERS[g]);
        end
    endgenerate

    always_comb begin
        // Vector stays at the reset value while no group is pending
        enc_vector  = VEC_RESET;
        any_pending = |group_hit;
        // Lowest index wins because it is scanned last
        for (int i = NUM_GROUP - 1; i >= 0; i--) begin
            if (group_hit[i]) begin
                enc_vector = GROUP_VECTOR[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic                 bus_req;
    logic                 wr_take;
    logic [REG_W-1:0]     wd;
    logic [NUM_SRC-1:0]   events;
    logic [NUM_SYNC-1:0]  pin_now;
    logic                 take_irq;

    assign bus_req  = avs_read | avs_write;
    // A write lands at the edge that ends the answer cycle
    assign wr_take  = avs_write & st_reg.ack;
    assign wd       = avs_writedata[REG_W-1:0];
    assign pin_now  = {timer_d_event_input, ext_irq_line_n};
    assign take_irq = irq_accept & irq_request & (st_reg.phase == MIC_IDLE);

    always_comb begin
        events            = '0;
        // Falling pin edge: previous sample high, newest sample low
        events[SRC_LINE0] = st_reg.sync_c[SRC_LINE0] & ~st_reg.sync_b[SRC_LINE0];
        events[SRC_LINE1] = st_reg.sync_c[SRC_LINE1] & ~st_reg.sync_b[SRC_LINE1];
        // Edge codes act on the pin level itself, so falling means high to low
        // The third stage holds the older sample, so each edge is seen in one cycle only
        events[SRC_LINE2] = edge_hit(st_reg.esr_one[1:0], st_reg.sync_c[2], st_reg.sync_b[2]);
        events[SRC_LINE3] = edge_hit(st_reg.esr_one[3:2], st_reg.sync_c[3], st_reg.sync_b[3]);
        events[SRC_LINE4] = edge_hit(st_reg.esr_two[1:0], st_reg.sync_c[4], st_reg.sync_b[4]);
        events[SRC_TA]    = timer_a_overflow;
        events[SRC_TB]    = timer_b_overflow;
        events[SRC_TC]    = timer_c_overflow;
        events[SRC_TD]    = timer_d_overflow
            | (capture_mode & edge_hit(st_reg.esr_two[3:2], st_reg.sync_c[SYNC_TIMER_D_EVENT_INPUT],
                                       st_reg.sync_b[SYNC_TIMER_D_EVENT_INPUT]));
        events[SRC_SER]   = serial_done;
        events[SRC_CONV]  = converter_done;
    end

    always_comb begin
        st_next = st_reg;

        // Two-stage synchronisers, third stage only for edge history
        st_next.sync_a = pin_now;
        st_next.sync_b = st_reg.sync_a;
        st_next.sync_c = st_reg.sync_b;

        // Bus: one wait state, read data captured on the first cycle
        st_next.ack   = bus_req & ~st_reg.ack;
        st_next.rdata = '0;
        if (avs_read & ~st_reg.ack) begin
            unique case (avs_address[ADDR_W-1:ADDR_LSB])
                REG_IE_LINE0:  st_next.rdata = {st_reg.mask[SRC_LINE0], st_reg.flag[SRC_LINE0], 1'b0, st_reg.ie};
                REG_LINE1_TA:  st_next.rdata = pair_bits(st_reg, SRC_LINE1, SRC_TA);
                REG_TB_TC:     st_next.rdata = pair_bits(st_reg, SRC_TB, SRC_TC);
                REG_TD_CONV:   st_next.rdata = pair_bits(st_reg, SRC_TD, SRC_CONV);
                REG_LINE2_3:   st_next.rdata = pair_bits(st_reg, SRC_LINE2, SRC_LINE3);
                REG_LINE4_SER: st_next.rdata = pair_bits(st_reg, SRC_LINE4, SRC_SER);
                default:       st_next.rdata = '0;
            endcase
        end

        // Software writes: masks freely, flags only towards zero
        if (wr_take) begin
            unique case (avs_address[ADDR_W-1:ADDR_LSB])
                REG_IE_LINE0: begin
                    st_next.ie              = wd[BIT_IE];
                    st_next.flag[SRC_LINE0] = st_reg.flag[SRC_LINE0] & wd[BIT_FLAG1];
                    st_next.mask[SRC_LINE0] = wd[BIT_MASK1];
                end
                REG_LINE1_TA: begin
                    st_next.flag[SRC_LINE1] = st_reg.flag[SRC_LINE1] & wd[BIT_FLAG0];
                    st_next.mask[SRC_LINE1] = wd[BIT_MASK0];
                    st_next.flag[SRC_TA]    = st_reg.flag[SRC_TA] & wd[BIT_FLAG1];
                    st_next.mask[SRC_TA]    = wd[BIT_MASK1];
                end
                REG_TB_TC: begin
                    st_next.flag[SRC_TB] = st_reg.flag[SRC_TB] & wd[BIT_FLAG0];
                    st_next.mask[SRC_TB] = wd[BIT_MASK0];
                    st_next.flag[SRC_TC] = st_reg.flag[SRC_TC] & wd[BIT_FLAG1];
                    st_next.mask[SRC_TC] = wd[BIT_MASK1];
                end
                REG_TD_CONV: begin
                    st_next.flag[SRC_TD]   = st_reg.flag[SRC_TD] & wd[BIT_FLAG0];
                    st_next.mask[SRC_TD]   = wd[BIT_MASK0];
                    st_next.flag[SRC_CONV] = st_reg.flag[SRC_CONV] & wd[BIT_FLAG1];
                    st_next.mask[SRC_CONV] = wd[BIT_MASK1];
                end
                REG_LINE2_3: begin
                    st_next.flag[SRC_LINE2] = st_reg.flag[SRC_LINE2] & wd[BIT_FLAG0];
                    st_next.mask[SRC_LINE2] = wd[BIT_MASK0];
                    st_next.flag[SRC_LINE3] = st_reg.flag[SRC_LINE3] & wd[BIT_FLAG1];
                    st_next.mask[SRC_LINE3] = wd[BIT_MASK1];
                end
                REG_LINE4_SER: begin
                    st_next.flag[SRC_LINE4] = st_reg.flag[SRC_LINE4] & wd[BIT_FLAG0];
                    st_next.mask[SRC_LINE4] = wd[BIT_MASK0];
                    st_next.flag[SRC_SER]   = st_reg.flag[SRC_SER] & wd[BIT_FLAG1];
                    st_next.mask[SRC_SER]   = wd[BIT_MASK1];
                end
                REG_ESR_ONE: st_next.esr_one = wd;
                REG_ESR_TWO: st_next.esr_two = wd;
                default: begin
                end
            endcase
        end

        // Hardware set wins over a same-cycle software clear
        st_next.flag = st_next.flag | events;

        if (return_from_irq_instr) begin
            st_next.ie = 1'b1;
        end

        // Acceptance sequence; the vector is frozen at acceptance
        unique case (st_reg.phase)
            MIC_IDLE: begin
                st_next.vector = stop_cancel_request ? VEC_RESET : enc_vector;
                if (take_irq) begin
                    st_next.vector = enc_vector;
                    st_next.phase  = MIC_FINISH;
                end
            end
            MIC_FINISH: st_next.phase = MIC_PUSH_A;
            MIC_PUSH_A: begin
                // Placed last so the sequence clear wins over a same-cycle return or write
                st_next.ie    = 1'b0;
                st_next.phase = MIC_PUSH_B;
            end
            MIC_PUSH_B: st_next.phase = MIC_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg         <= '0;
            st_reg.ie      <= 1'b0;
            st_reg.flag    <= FLAGS_RESET;
            st_reg.mask    <= MASKS_RESET;
            st_reg.esr_one <= ESR_RESET;
            st_reg.esr_two <= ESR_RESET;
            // Idle pin level, so releasing reset shows no false edge
            st_reg.sync_a  <= '1;
            st_reg.sync_b  <= '1;
            st_reg.sync_c  <= '1;
            st_reg.vector  <= VEC_RESET;
            st_reg.phase   <= MIC_IDLE;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest     = bus_req & ~st_reg.ack;
    // Read data stands only in the cycle in which waitrequest is low
    assign avs_readdata        = {{(32 - REG_W){1'b0}}, st_reg.rdata};
    assign irq_request         = st_reg.ie & any_pending & (st_reg.phase == MIC_IDLE);
    assign stop_cancel_request = stop_mode & stop_cancel_input;
    assign irq_vector          = st_reg.vector;
    assign finish_cycle        = st_reg.phase == MIC_FINISH;
    assign stack_push          = (st_reg.phase == MIC_PUSH_A) | (st_reg.phase == MIC_PUSH_B);
    assign vector_jump         = st_reg.phase == MIC_PUSH_B;
    assign global_irq_enable   = st_reg.ie;

endmodule : mic_irq_ctrl

// *** tb/mic_irq_ctrl_props.sv ***
// Checker: port-level properties of the interrupt controller
module mic_irq_ctrl_props
    import mic_pkg::*;
(
    // Clock and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    // Sequencer and stop
    input wire logic        irq_accept,
    input wire logic        return_from_irq_instr,
    input wire logic        irq_request,
    input wire logic        stop_mode,
    input wire logic        stop_cancel_input,
    input wire logic        stop_cancel_request,
    input wire logic [15:0] irq_vector,
    input wire logic        finish_cycle,
    input wire logic        stack_push,
    input wire logic        vector_jump,
    input wire logic        global_irq_enable
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    chk_seq_start: assert property (ce && irq_accept && irq_request |=> finish_cycle && !stack_push)
        else $error("accept not followed by finish cycle");
    chk_push_two: assert property (finish_cycle |=> stack_push [*2] ##1 !stack_push)
        else $error("stack push not exactly two cycles");
    chk_jump_third: assert property (finish_cycle |=> !vector_jump ##1 vector_jump)
        else $error("jump not in third cycle");
    chk_ie_cleared: assert property (finish_cycle |=> global_irq_enable ##1 !global_irq_enable)
        else $error("enable not cleared by second cycle");
    chk_req_gated: assert property (irq_request |-> global_irq_enable && !finish_cycle && !stack_push)
        else $error("request without enable or while busy");
    chk_vec_held: assert property (finish_cycle |=> $stable(irq_vector) [*2])
        else $error("vector moved during sequence");
    chk_stop_only: assert property (stop_cancel_request == (stop_mode && stop_cancel_input))
        else $error("stop cancel request outside stop mode");
    chk_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait state");
    chk_rti_sets: assert property (return_from_irq_instr && !stack_push && !avs_write |=> global_irq_enable)
        else $error("return did not set enable");
    chk_reset_state: assert property ($fell(rst) |-> !global_irq_enable && !irq_request && !finish_cycle)
        else $error("state not cleared by reset");
    chk_read_high: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:4] == 28'h000_0000)
        else $error("unused read bits not zero");
endmodule : mic_irq_ctrl_props

bind mic_irq_ctrl mic_irq_ctrl_props u_props (
    .clk, .rst, .ce, .avs_read, .avs_write, .avs_waitrequest, .avs_readdata,
    .irq_accept, .return_from_irq_instr, .irq_request, .stop_mode, .stop_cancel_input,
    .stop_cancel_request, .irq_vector, .finish_cycle, .stack_push, .vector_jump, .global_irq_enable
);

// *** tb/mic_core_model.sv ***
// Model: core sequencer that takes requests, runs a handler and returns
module mic_core_model #(
    parameter int HANDLER_CYCLES = 40
) (
    // Clock, reset, bench control
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        take_en,
    // Controller side
    input  wire logic        irq_request,
    input  wire logic        vector_jump,
    input  wire logic [15:0] irq_vector,
    output logic             irq_accept,
    output logic             return_from_irq_instr,
    output logic [15:0]      taken_vector,
    output logic             busy
);
    int cnt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_accept            <= 1'b0;
            return_from_irq_instr <= 1'b0;
            taken_vector          <= 16'h0000;
            busy                  <= 1'b0;
            cnt                   <= 0;
        end else begin
            // One-cycle accept pulse, never while a handler runs
            irq_accept            <= take_en && irq_request && !irq_accept && !busy;
            return_from_irq_instr <= 1'b0;
            if (irq_accept && irq_request) begin
                busy <= 1'b1;
            end
            if (vector_jump) begin
                taken_vector <= irq_vector;
                cnt          <= HANDLER_CYCLES;
            end else if (cnt == 1) begin
                return_from_irq_instr <= 1'b1;
                busy                  <= 1'b0;
                cnt                   <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : mic_core_model

// *** tb/mic_irq_ctrl_tb.sv ***
// Testbench: self-checking scenarios for the interrupt controller
module mic_irq_ctrl_tb
    import mic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [4:0]  ext_irq_line_n = 5'h1F;
    logic [5:0]  ev = 6'h00;
    logic        stop_mode = 1'b0;
    logic        stop_cancel_input = 1'b0;
    logic        take_en = 1'b0;
    logic        irq_accept, rti, irq_request, scr, finish_cycle, stack_push, vector_jump, gie, busy;
    logic [15:0] irq_vector, taken_vector;
    int          fail_count = 0;
    int          samples_checked = 0;

    mic_irq_ctrl dut (
        .clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_irq_line_n(ext_irq_line_n), .timer_d_event_input(1'b0),
        .capture_mode(1'b0), .timer_a_overflow(ev[5]), .timer_b_overflow(ev[4]), .timer_c_overflow(ev[3]),
        .timer_d_overflow(ev[2]), .serial_done(ev[1]), .converter_done(ev[0]), .stop_mode(stop_mode),
        .stop_cancel_input(stop_cancel_input), .irq_accept(irq_accept), .return_from_irq_instr(rti),
        .irq_request(irq_request), .stop_cancel_request(scr), .irq_vector(irq_vector),
        .finish_cycle(finish_cycle), .stack_push(stack_push), .vector_jump(vector_jump),
        .global_irq_enable(gie));

    mic_core_model core (
        .clk(clk), .rst(rst), .take_en(take_en), .irq_request(irq_request), .vector_jump(vector_jump),
        .irq_vector(irq_vector), .irq_accept(irq_accept), .return_from_irq_instr(rti),
        .taken_vector(taken_vector), .busy(busy));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low at a rising edge, then releases and idles one cycle
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [3:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {28'h000_0000, wd};
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [3:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr

    task automatic rdc(input logic [5:0] idx, input logic [3:0] e);
        logic [31:0] x;
        bus(1'b0, idx, 4'h0, x);
        chk($sformatf("reg %h", idx), x, {28'h000_0000, e});
    endtask : rdc

    task automatic t_reset();
        logic [5:0] ix [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h22, 6'h23, 6'h26, 6'h10};
        logic [3:0] ex [8] = '{4'h8, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'h0, 4'h0};
        for (int i = 0; i < 8; i++) rdc(ix[i], ex[i]);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_flags();
        wr(REG_LINE1_TA, 4'h5);
        rdc(REG_LINE1_TA, 4'h0);
        ev <= 6'h20;
        @(posedge clk);
        ev <= 6'h00;
        rdc(REG_LINE1_TA, 4'h4);
        wr(REG_LINE1_TA, 4'h1);
        rdc(REG_LINE1_TA, 4'h0);
        $display("t_flags done");
    endtask : t_flags

    task automatic t_prio();
        logic [15:0] vec [5] = '{16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E};
        logic [5:0]  ci [5] = '{REG_LINE1_TA, REG_TB_TC, REG_TB_TC, REG_TD_CONV, REG_LINE4_SER};
        logic [3:0]  cd [5] = '{4'h1, 4'h4, 4'h0, 4'h0, 4'h1};
        wr(REG_IE_LINE0, 4'h5);
        wr(REG_TB_TC, 4'h5);
        wr(REG_TD_CONV, 4'h5);
        wr(REG_LINE4_SER, 4'h5);
        ev <= 6'h3F;
        @(posedge clk);
        ev <= 6'h00;
        for (int i = 0; i < 5; i++) begin
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("vector", irq_vector, vec[i]);
            chk("request", irq_request, 1'b1);
            @(posedge clk);
            wr(ci[i], cd[i]);
        end
        wr(REG_LINE4_SER, 4'hC);
        ev <= 6'h02;
        @(posedge clk);
        ev <= 6'h00;
        @(negedge clk);
        chk("masked", irq_request, 1'b0);
        @(posedge clk);
        wr(REG_IE_LINE0, 4'h4);
        wr(REG_LINE4_SER, 4'h5);
        @(negedge clk);
        chk("no enable", irq_request, 1'b0);
        @(posedge clk);
        wr(REG_LINE4_SER, 4'h1);
        $display("t_prio done");
    endtask : t_prio

    task automatic t_seq();
        wr(REG_IE_LINE0, 4'h5);
        take_en          <= 1'b1;
        ext_irq_line_n[0] <= 1'b0;
        for (int n = 0; n < 30 && busy !== 1'b1; n++) @(posedge clk);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("enable in handler", gie, 1'b0);
        chk("taken vector", taken_vector, VEC_RESET + 16'h0002);
        @(posedge clk);
        wr(REG_IE_LINE0, 4'h0);
        for (int n = 0; n < 80 && busy !== 1'b0; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        rdc(REG_IE_LINE0, 4'h1);
        ext_irq_line_n[0] <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(REG_IE_LINE0, 4'h1);
        take_en <= 1'b0;
        $display("t_seq done");
    endtask : t_seq

    task automatic t_edge();
        for (int c = 0; c < 4; c++) begin
            logic f;
            f = c[0];
            wr(REG_ESR_ONE, {c[1:0], c[1:0]});
            ext_irq_line_n[3:2] <= 2'b00;
            repeat (6) @(posedge clk);
            rdc(REG_LINE2_3, {1'b1, f, 1'b1, f});
            f = (c != 0);
            ext_irq_line_n[3:2] <= 2'b11;
            repeat (6) @(posedge clk);
            rdc(REG_LINE2_3, {1'b1, f, 1'b1, f});
            wr(REG_LINE2_3, 4'hA);
        end
        wr(REG_ESR_TWO, 4'h1);
        ext_irq_line_n[4] <= 1'b0;
        repeat (6) @(posedge clk);
        rdc(REG_LINE4_SER, 4'h1);
        $display("t_edge done");
    endtask : t_edge

    task automatic t_stop();
        stop_cancel_input <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("cancel outside stop", scr, 1'b0);
        @(posedge clk);
        stop_mode <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("cancel in stop", scr, 1'b1);
        chk("cancel vector", irq_vector, VEC_RESET);
        @(posedge clk);
        stop_mode         <= 1'b0;
        stop_cancel_input <= 1'b0;
        $display("t_stop done");
    endtask : t_stop

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_flags();
        t_prio();
        t_seq();
        t_edge();
        t_stop();
        close_out();
    end
endmodule : mic_irq_ctrl_tb
